// ### hw/ags_pkg.sv
`default_nettype none
// ==========================================================
// shared constants of the active group selector
package ags_pkg;
   localparam int unsigned NBANK      = 6;
   localparam int unsigned BW         = 3;   // bank number width
   localparam int unsigned TW         = 16;  // timer setting width
   localparam int unsigned AW         = 8;   // apb address width

   // ==========================================================
   // register byte offsets
   localparam logic [7:0] OFS_CTRL    = 8'h00;
   localparam logic [7:0] OFS_QUAL    = 8'h04;
   localparam logic [7:0] OFS_GATE    = 8'h08;
   localparam logic [7:0] OFS_DEBNC   = 8'h0C;
   localparam logic [7:0] OFS_CMD     = 8'h10;
   localparam logic [7:0] OFS_STATUS  = 8'h14;
   localparam logic [7:0] OFS_NVCNT   = 8'h18;
   localparam logic [7:0] OFS_EDIT    = 8'h1C;

   // ==========================================================
   // field positions
   localparam int unsigned CTRL_MODE_LSB  = 0;
   localparam int unsigned CTRL_BANKA_LSB = 4;
   localparam int unsigned CTRL_BANKB_LSB = 8;
   localparam int unsigned CMD_BANK_LSB   = 0;
   localparam int unsigned CMD_PB_BIT     = 8;
   localparam int unsigned ST_ANY_BIT     = 6;
   localparam int unsigned ST_FRZ_BIT     = 7;
   localparam int unsigned ST_FAIL_BIT    = 8;
   localparam int unsigned ST_GATE_BIT    = 9;

   // ==========================================================
   // modes and reset values
   localparam logic [1:0]  MODE_EXT   = 2'h0;  // equations from sel_eq_i
   localparam logic [1:0]  MODE_CODE  = 2'h1;  // three-input code
   localparam logic [1:0]  MODE_PULSE = 2'h2;  // single pulse input toggles A/B
   localparam logic [1:0]  RST_MODE   = 2'h0;
   localparam logic [2:0]  RST_BANKA  = 3'h1;
   localparam logic [2:0]  RST_BANKB  = 3'h4;
   localparam logic [15:0] RST_QUAL   = 16'h0004;
   localparam logic [15:0] RST_GATE   = 16'h0010;
   localparam logic [15:0] RST_DEBNC  = 16'h0002;
   localparam logic [15:0] QUAL_MAX   = 16'h3E80; // 16000 cycles
   localparam logic [2:0]  BANK_DFLT  = 3'h1;
endpackage
`default_nettype wire

// ### hw/ags_hold_timer.sv
`default_nettype none
// ==========================================================
// pickup timer: q follows in after in held limit_i+1 cycles;
// SYMM=1 delays the fall the same way (debounce), SYMM=0 drops at once
module ags_hold_timer #(
   parameter int unsigned CW   = 16,
   parameter bit          SYMM = 1'b0
) (
   input  wire logic          mclk_i,    // clock
   input  wire logic          resetn_i,  // async reset, low
   input  wire logic          clr_i,     // synchronous clear
   input  wire logic          in_i,      // timer input
   input  wire logic [CW-1:0] limit_i,   // pickup count
   output logic               q_o        // timer output
);
   logic [CW-1:0] cnt;
   logic          q;
   wire  logic    differ   = in_i != q;
   wire  logic    drop_now = !SYMM && !in_i;
   wire  logic    expire   = cnt >= limit_i;

   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         q   <= 1'b0;
         cnt <= '0;
      end else if (clr_i || drop_now) begin
         q   <= 1'b0;
         cnt <= '0;
      end else if (differ && expire) begin
         q   <= in_i;  // see R4
         cnt <= '0;
      end else if (differ) begin
         cnt <= cnt + 1'b1;
      end else begin
         cnt <= '0;
      end
   end
   assign q_o = q;

   a_pickup_held: assert property (@(posedge mclk_i) disable iff (!resetn_i) // see R4
      $rose(q_o) |-> $past(in_i) && $past(differ) && $past(expire))
      else $error("timer output rose without a held input");
endmodule // ags_hold_timer
`default_nettype wire

// ### hw/ags_group_sel.sv
`default_nettype none
// Operation
// R1: all logic timers reset on bank change
// R2: short select pulses never switch banks
// R3: new bank flag set, old cleared
// R4: timer asserts after continuous pickup time
// R5: gate pickup longer than select pulse
// R6: three-input code decodes banks one to six
// R7: no select keeps last bank active
// R8: no select lets command or pushbutton switch
// R9: active bank restored after power cycle
// R10: edit of other bank leaves protection running
// R11: edited select equations are re-evaluated
// R12: store bank on change, report endurance failure
// R13: keep changes near ten per day
// R14: equations must not cycle continuously
// R15: every select contact input is debounced
// R16: rotary selector qualify delay 180-300 cycles
// R17: exactly one of six banks active
// R18: qualify delay programmable up to 16000
// R19: freeze outputs and reset timers while switching
// R20: any select blocks command and pushbutton
// R21: lowest qualified bank wins ties
module ags_group_sel #(
   parameter int unsigned FREEZE_CYC     = 16,
   parameter int unsigned NV_WRITE_LIMIT = 100000
) (
   input  wire logic        mclk_i,                // 250 MHz clock
   input  wire logic        resetn_i,              // async reset, low
   input  wire logic        psel_i,                // apb select
   input  wire logic        penable_i,             // apb enable
   input  wire logic        pwrite_i,              // apb write
   input  wire logic [7:0]  paddr_i,               // apb byte address
   input  wire logic [31:0] pwdata_i,              // apb write data
   output logic      [31:0] prdata_o,              // apb read data
   output logic             pready_o,              // apb ready
   output logic             pslverr_o,             // apb error
   input  wire logic [5:0]  sel_eq_i,              // external select equations
   input  wire logic [2:0]  select_input_i,        // coded select contacts
   input  wire logic        pulse_select_input_i,  // pulsed select contact
   input  wire logic [2:0]  nv_restore_i,          // stored bank at power-up
   output logic             nv_wr_o,               // store strobe
   output logic      [2:0]  nv_data_o,             // bank number stored
   output logic             nv_fail_o,             // endurance exhausted
   output logic      [5:0]  active_flag_o,         // one-hot active bank
   output logic             freeze_o,              // output contacts frozen
   output logic             timer_reset_o          // reset logic timers
);
   localparam int unsigned NB = ags_pkg::NBANK;
   localparam int unsigned TW = ags_pkg::TW;

   typedef enum logic [1:0] {AGS_INIT, AGS_RUN, AGS_SWITCH} ags_state_t;

   // ==========================================================
   // registers
   ags_state_t     state;
   logic [2:0]     active;     // zero-based bank index
   logic [1:0]     mode;
   logic [2:0]     bank_a;
   logic [2:0]     bank_b;
   logic [TW-1:0]  qual_dly;
   logic [TW-1:0]  gate_pu;
   logic [TW-1:0]  debnc;
   logic [15:0]    frz_cnt;
   logic [31:0]    nv_cnt;
   logic           nv_fail;
   logic           nv_wr;
   logic           reload;
   logic [31:0]    prdata;

   // ==========================================================
   // apb decode
   wire logic acc      = psel_i && penable_i;
   wire logic wr       = acc && pwrite_i;
   wire logic hit_ctrl = paddr_i == ags_pkg::OFS_CTRL;
   wire logic hit_qual = paddr_i == ags_pkg::OFS_QUAL;
   wire logic hit_gate = paddr_i == ags_pkg::OFS_GATE;
   wire logic hit_deb  = paddr_i == ags_pkg::OFS_DEBNC;
   wire logic hit_cmd  = paddr_i == ags_pkg::OFS_CMD;
   wire logic hit_st   = paddr_i == ags_pkg::OFS_STATUS;
   wire logic hit_nvc  = paddr_i == ags_pkg::OFS_NVCNT;
   wire logic hit_edit = paddr_i == ags_pkg::OFS_EDIT;
   wire logic mapped   = hit_ctrl | hit_qual | hit_gate | hit_deb | hit_cmd |
                         hit_st | hit_nvc | hit_edit;

   wire logic [2:0]  cmd_bank = pwdata_i[ags_pkg::CMD_BANK_LSB +: 3];
   wire logic        cmd_pb   = pwdata_i[ags_pkg::CMD_PB_BIT];
   wire logic [2:0]  edit_bnk = pwdata_i[2:0];
   wire logic [15:0] wq       = pwdata_i[15:0];
   wire logic [15:0] wq_clamp = (wq > ags_pkg::QUAL_MAX) ? ags_pkg::QUAL_MAX : wq;

   // ==========================================================
   // input debounce: three coded contacts and the pulse contact
   logic [3:0] raw_in;
   logic [3:0] deb_in;
   assign raw_in = {pulse_select_input_i, select_input_i};
   for (genvar g = 0; g < 4; g++) begin : g_deb
      ags_hold_timer #(.CW(TW), .SYMM(1'b1)) u_deb (  // see R15
         .mclk_i   (mclk_i),
         .resetn_i (resetn_i),
         .clr_i    (1'b0),
         .in_i     (raw_in[g]),
         .limit_i  (debnc),
         .q_o      (deb_in[g])
      );
   end
   wire logic [2:0] code    = deb_in[2:0];
   wire logic       pulse_d = deb_in[3];

   // ==========================================================
   // select equations per mode
   logic [5:0] onehot;
   logic [5:0] eq;
   logic       gate_out;
   logic       tclr;
   wire  logic [5:0] bit_a  = 6'h01 << bank_a;
   wire  logic [5:0] bit_b  = 6'h01 << bank_b;
   wire  logic [5:0] code_eq = (code == 3'h0 || code == 3'h7) ? 6'h00
                                : (6'h01 << (code - 3'h1));           // see R6
   wire  logic in_a  = onehot == bit_a;
   wire  logic in_b  = onehot == bit_b;
   wire  logic [5:0] pulse_eq = (pulse_d && gate_out && in_a) ? bit_b
                              : (pulse_d && gate_out && in_b) ? bit_a : 6'h00;
   assign eq = (mode == ags_pkg::MODE_CODE)  ? code_eq
             : (mode == ags_pkg::MODE_PULSE) ? pulse_eq
             : (mode == ags_pkg::MODE_EXT)   ? sel_eq_i : 6'h00;
   assign onehot = 6'h01 << active;

   // gate timer fed by the pulse scheme's active flag
   wire logic gate_in = in_a | in_b;
   ags_hold_timer #(.CW(TW), .SYMM(1'b0)) u_gate (  // see R4
      .mclk_i   (mclk_i),
      .resetn_i (resetn_i),
      .clr_i    (tclr),
      .in_i     (gate_in),
      .limit_i  (gate_pu),
      .q_o      (gate_out)
   );

   // ==========================================================
   // per-bank qualify timers; own bank never needs qualifying
   logic [5:0] qual;
   for (genvar b = 0; b < NB; b++) begin : g_qual
      ags_hold_timer #(.CW(TW), .SYMM(1'b0)) u_q (  // see R2
         .mclk_i   (mclk_i),
         .resetn_i (resetn_i),
         .clr_i    (tclr),
         .in_i     (eq[b] && !onehot[b]),
         .limit_i  (qual_dly),
         .q_o      (qual[b])
      );
   end

   // lowest qualified bank wins
   logic [2:0] pick;
   always_comb begin
      pick = 3'h0;
      for (int i = NB - 1; i >= 0; i--) begin
         if (qual[i]) begin
            pick = i[2:0];  // see R21
         end
      end
   end

   // ==========================================================
   // change decision
   wire logic any_eq  = |eq;
   wire logic own_eq  = |(eq & onehot);
   wire logic run     = state == AGS_RUN;
   wire logic eq_go   = !own_eq && |qual;                              // see R7
   wire logic cmd_ok  = wr && hit_cmd && !any_eq;                      // see R20
   wire logic cmd_go  = cmd_ok && !cmd_pb && cmd_bank >= 3'h1 && cmd_bank <= 3'h6;
   wire logic pb_go   = cmd_ok && cmd_pb;                              // see R8
   wire logic [2:0] pb_next  = (active == 3'h5) ? 3'h0 : active + 3'h1;
   wire logic [2:0] target   = eq_go ? pick
                              : pb_go ? pb_next : cmd_bank - 3'h1;
   wire logic start = run && (eq_go || cmd_go || pb_go) && target != active;
   wire logic frz_done = frz_cnt == 16'(FREEZE_CYC - 1);
   wire logic [2:0] rst_bank = (nv_restore_i >= 3'h1 && nv_restore_i <= 3'h6)
                              ? nv_restore_i - 3'h1 : ags_pkg::BANK_DFLT - 3'h1;
   wire logic edit_own  = wr && hit_edit && edit_bnk == active + 3'h1;  // see R10

   // ==========================================================
   // state and active bank
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state   <= AGS_INIT;
         active  <= 3'h0;
         frz_cnt <= '0;
      end else begin
         case (state)
            AGS_INIT: begin
               active <= rst_bank;  // see R9
               state  <= AGS_RUN;
            end
            AGS_RUN: begin
               if (start) begin
                  active  <= target;  // see R3
                  frz_cnt <= '0;
                  state   <= AGS_SWITCH;
               end
            end
            AGS_SWITCH: begin
               frz_cnt <= frz_cnt + 16'h0001;
               if (frz_done) begin
                  state <= AGS_RUN;  // see R19
               end
            end
            default: state <= AGS_INIT;
         endcase
      end
   end

   // timers cleared during a change and on reload of the active bank
   assign tclr = (state == AGS_SWITCH) || reload;  // see R1

   // ==========================================================
   // nonvolatile store and endurance
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         nv_wr   <= 1'b0;
         nv_data_o <= 3'h0;
         nv_cnt  <= '0;
         nv_fail <= 1'b0;
         reload  <= 1'b0;
      end else begin
         nv_wr  <= start;
         reload <= edit_own;
         if (start) begin
            nv_data_o <= target + 3'h1;  // see R12
            if (nv_cnt != 32'hFFFF_FFFF) begin
               nv_cnt <= nv_cnt + 32'h1;
            end
         end
         if (nv_cnt >= NV_WRITE_LIMIT) begin
            nv_fail <= 1'b1;  // see R12
         end
      end
   end

   // ==========================================================
   // writable settings; a write to CTRL may retarget equations at once
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         mode     <= ags_pkg::RST_MODE;
         bank_a   <= ags_pkg::RST_BANKA - 3'h1;
         bank_b   <= ags_pkg::RST_BANKB - 3'h1;
         qual_dly <= ags_pkg::RST_QUAL;
         gate_pu  <= ags_pkg::RST_GATE;
         debnc    <= ags_pkg::RST_DEBNC;
      end else if (wr) begin
         if (hit_ctrl) begin
            mode   <= pwdata_i[ags_pkg::CTRL_MODE_LSB +: 2];  // see R11
            bank_a <= pwdata_i[ags_pkg::CTRL_BANKA_LSB +: 3] - 3'h1;
            bank_b <= pwdata_i[ags_pkg::CTRL_BANKB_LSB +: 3] - 3'h1;
         end else if (hit_qual) begin
            qual_dly <= wq_clamp;  // see R18
         end else if (hit_gate) begin
            gate_pu <= wq;
         end else if (hit_deb) begin
            debnc <= wq;
         end
      end
   end

   // ==========================================================
   // read data
   wire logic [31:0] rd_ctrl = {20'h0, 1'b0, bank_b + 3'h1, 1'b0, bank_a + 3'h1, 2'h0, mode};
   wire logic [31:0] rd_st   = {22'h0, gate_out, nv_fail, freeze_o, any_eq, onehot};
   wire logic [31:0] rd_mux  = hit_ctrl ? rd_ctrl
                             : hit_qual ? {16'h0, qual_dly}
                             : hit_gate ? {16'h0, gate_pu}
                             : hit_deb  ? {16'h0, debnc}
                             : hit_st   ? rd_st
                             : hit_nvc  ? nv_cnt : 32'h0;
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         prdata <= 32'h0;
      end else if (psel_i && !penable_i && !pwrite_i) begin
         prdata <= rd_mux;
      end
   end

   assign prdata_o      = prdata;
   assign pready_o      = 1'b1;
   assign pslverr_o     = acc && !mapped;
   assign nv_wr_o       = nv_wr;
   assign nv_fail_o     = nv_fail;
   assign active_flag_o = (state == AGS_INIT) ? 6'h00 : onehot;  // see R17
   assign freeze_o      = state == AGS_SWITCH;                  // see R19
   assign timer_reset_o = tclr;

   // ==========================================================
   // checks
   logic [15:0] frz_len;
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         frz_len <= '0;
      end else begin
         frz_len <= freeze_o ? frz_len + 16'h0001 : 16'h0000;
      end
   end

   a_one_hot_bank: assert property (@(posedge mclk_i) disable iff (!resetn_i) // see R17
      state != AGS_INIT |-> $onehot(active_flag_o))
      else $error("active flags not one-hot");
   a_switch_cause: assert property (@(posedge mclk_i) disable iff (!resetn_i) // see R2
      $past(state) == AGS_RUN && $changed(active) |-> $past(|qual) || $past(cmd_ok))
      else $error("bank changed without a qualified select or command");
   a_hold_no_select: assert property (@(posedge mclk_i) disable iff (!resetn_i) // see R7
      run && !any_eq && !wr |=> $stable(active))
      else $error("bank moved with no select and no command");
   a_cmd_blocked: assert property (@(posedge mclk_i) disable iff (!resetn_i) // see R20
      run && any_eq && !eq_go |=> $stable(active))
      else $error("command honoured while a select is asserted");
   a_timers_cleared: assert property (@(posedge mclk_i) disable iff (!resetn_i) // see R1
      start |=> timer_reset_o && freeze_o ##1 timer_reset_o)
      else $error("timers not reset on bank change");
   a_freeze_length: assert property (@(posedge mclk_i) disable iff (!resetn_i) // see R19
      $fell(freeze_o) |-> frz_len == 16'(FREEZE_CYC))
      else $error("freeze did not last the set time");
   a_nv_on_change: assert property (@(posedge mclk_i) disable iff (!resetn_i) // see R12
      start |=> nv_wr_o && nv_data_o == active + 3'h1)
      else $error("bank change not stored");
   a_lowest_wins: assert property (@(posedge mclk_i) disable iff (!resetn_i) // see R21
      start && eq_go |=> active == $past(pick) && ($past(qual) & (6'h01 << active) - 6'h01) == 6'h00)
      else $error("a higher bank won over a lower qualified one");
   a_edit_other: assert property (@(posedge mclk_i) disable iff (!resetn_i) // see R10
      run && wr && hit_edit && !edit_own && !start |=> !freeze_o && !timer_reset_o)
      else $error("edit of another bank disturbed protection");

   c_eq_switch: cover property (@(posedge mclk_i) disable iff (!resetn_i) start && eq_go);
   c_cmd_switch: cover property (@(posedge mclk_i) disable iff (!resetn_i) start && cmd_go);
   c_pb_switch: cover property (@(posedge mclk_i) disable iff (!resetn_i) start && pb_go);
   c_pulse_toggle: cover property (@(posedge mclk_i) disable iff (!resetn_i)
      mode == ags_pkg::MODE_PULSE && start);
endmodule // ags_group_sel
`default_nettype wire

// ### test/ags_contacts.sv
`default_nettype none
// ==========================================================
// rotary selector switch and pulsed contact facing the selector
module ags_contacts #(
   parameter int unsigned DWELL = 3,
   parameter int unsigned PW    = 10
) (
   input  wire logic       mclk_i,  // clock
   input  wire logic [2:0] pos_i,   // wanted switch position
   input  wire logic       fire_i,  // start one contact pulse
   output logic      [2:0] code_o,  // coded contacts
   output logic            pulse_o  // pulsed contact
);
   timeunit 1ns;
   timeprecision 1ps;
   int unsigned dw = 0;
   int unsigned pc = 0;
   initial begin
      code_o = 3'h0;
      pulse_o = 1'b0;
   end
   // the switch passes every position in between, resting briefly on each
   always @(posedge mclk_i) begin
      if (code_o != pos_i) begin
         dw <= (dw == DWELL) ? 0 : dw + 1;
         if (dw == DWELL) begin
            code_o <= (code_o < pos_i) ? code_o + 3'h1 : code_o - 3'h1;
         end
      end
      // pulse kept shorter than the gate pickup: one change per pulse
      pc <= fire_i ? PW : ((pc != 0) ? pc - 1 : 0);
      pulse_o <= fire_i || (pc > 1);
   end
endmodule // ags_contacts
`default_nettype wire

// ### test/active_group_selector_tb.sv
`default_nettype none
module active_group_selector_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int unsigned FRZ = 4;
   logic mclk_i, resetn_i, psel, penable, pwrite, pready, pslverr, perr;
   logic pulse, fire, nv_wr, nv_fail, freeze, trst;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rdat;
   logic [5:0] sel_eq, flag;
   logic [2:0] code, nv_restore, nv_data, pos, last_nv;
   int n_errors = 0, comparisons = 0;
   int n_frz = 0, n_wr = 0, n_tro = 0, fl = 0, frz_len = 0, bad_tr = 0, fx, tx;

   ags_group_sel #(.FREEZE_CYC(FRZ), .NV_WRITE_LIMIT(3)) uut (
      .mclk_i(mclk_i), .resetn_i(resetn_i), .psel_i(psel), .penable_i(penable),
      .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
      .pready_o(pready), .pslverr_o(pslverr), .sel_eq_i(sel_eq), .select_input_i(code),
      .pulse_select_input_i(pulse), .nv_restore_i(nv_restore), .nv_wr_o(nv_wr),
      .nv_data_o(nv_data), .nv_fail_o(nv_fail), .active_flag_o(flag),
      .freeze_o(freeze), .timer_reset_o(trst));
   ags_contacts #(.DWELL(3), .PW(10)) contacts (
      .mclk_i(mclk_i), .pos_i(pos), .fire_i(fire), .code_o(code), .pulse_o(pulse));

   initial begin
      mclk_i = 1'b0;
      forever #2 mclk_i = ~mclk_i;
   end

   // ==========================================================
   // monitor: stores, freeze windows, timer clears
   always @(posedge mclk_i) begin
      if (nv_wr === 1'b1) begin
         n_wr <= n_wr + 1;
         last_nv <= nv_data;
      end
      if (freeze === 1'b1) begin
         fl <= fl + 1;
         if (fl == 0) n_frz <= n_frz + 1;
         if (trst !== 1'b1) bad_tr <= bad_tr + 1;
      end else begin
         if (fl != 0) frz_len <= fl;
         fl <= 0;
         if (trst === 1'b1) n_tro <= n_tro + 1;
      end
   end

   // ==========================================================
   // tasks
   task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task fchk(input logic [5:0] e);
      chk("active flags", {26'h0, e}, {26'h0, flag});
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk_i);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk_i);
      penable <= 1'b1;
      @(posedge mclk_i);
      while (pready !== 1'b1) @(posedge mclk_i);
      rdat = prdata;
      perr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task rd(input string n, input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(n, e, rdat);
   endtask
   task cyc(input int n);
      repeat (n) @(posedge mclk_i);
   endtask
   // waits bounded for a bank change, then past its freeze window
   task settle;
      int k;
      k = 0;
      while (freeze !== 1'b1 && k < 300) begin
         @(posedge mclk_i);
         k++;
      end
      chk("bank change", 32'h1, {31'h0, freeze});
      cyc(FRZ + 2);
   endtask
   task give_verdict;
      if (n_errors == 0 && comparisons > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   initial begin
      #100000;
      n_errors++;
      give_verdict;
   end

   // ==========================================================
   // main sequence
   initial begin
      resetn_i = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      sel_eq = 6'h00;
      nv_restore = 3'h5;
      pos = 3'h0;
      fire = 1'b0;
      cyc(4);
      resetn_i <= 1'b1;
      cyc(3);
      fchk(6'h10);
      rd("ctrl", ags_pkg::OFS_CTRL, 32'h00000410);
      chk("slverr mapped", 32'h0, {31'h0, perr});
      rd("qual", ags_pkg::OFS_QUAL, 32'h00000004);
      rd("gate", ags_pkg::OFS_GATE, 32'h00000010);
      rd("debounce", ags_pkg::OFS_DEBNC, 32'h00000002);
      rd("status", ags_pkg::OFS_STATUS, 32'h00000010);
      rd("unmapped", 8'h20, 32'h00000000);
      chk("slverr", 32'h1, {31'h0, perr});
      wr(ags_pkg::OFS_QUAL, 32'h0000FFFF);
      rd("qual clamp", ags_pkg::OFS_QUAL, 32'h00003E80);
      wr(ags_pkg::OFS_QUAL, 32'h00000003);
      // a select one cycle short of the delay must not switch
      sel_eq <= 6'h04;
      cyc(3);
      sel_eq <= 6'h00;
      cyc(12);
      fchk(6'h10);
      sel_eq <= 6'h04;
      settle;
      fchk(6'h04);
      chk("stored bank", 32'h3, {29'h0, last_nv});
      wr(ags_pkg::OFS_CMD, 32'h00000006);
      cyc(8);
      fchk(6'h04);
      sel_eq <= 6'h00;
      cyc(20);
      fchk(6'h04);
      // a command naming no bank is ignored
      wr(ags_pkg::OFS_CMD, 32'h00000007);
      cyc(8);
      fchk(6'h04);
      wr(ags_pkg::OFS_CMD, 32'h00000006);
      settle;
      fchk(6'h20);
      wr(ags_pkg::OFS_CMD, 32'h00000100);
      settle;
      fchk(6'h01);
      sel_eq <= 6'h30;
      settle;
      fchk(6'h10);
      sel_eq <= 6'h00;
      // edits: other bank untouched, active bank clears timers only
      fx = n_frz;
      tx = n_tro;
      wr(ags_pkg::OFS_EDIT, 32'h00000002);
      cyc(6);
      chk("edit other clears", tx, n_tro);
      wr(ags_pkg::OFS_EDIT, 32'h00000005);
      cyc(6);
      chk("edit active clears", tx + 1, n_tro);
      chk("edit freezes", fx, n_frz);
      // ==========================================================
      // three-input code through the selector switch
      pos <= 3'h2;
      cyc(20);
      wr(ags_pkg::OFS_QUAL, 32'h00000014);
      wr(ags_pkg::OFS_CTRL, 32'h00000411);
      settle;
      fchk(6'h02);
      for (int b = 1; b <= 6; b++) begin
         if (b != 2) begin
            pos <= b[2:0];
            settle;
            fchk(6'h01 << (b - 1));
         end
      end
      fx = n_frz;
      pos <= 3'h3;
      settle;
      cyc(40);
      fchk(6'h04);
      chk("passing positions", fx + 1, n_frz);
      pos <= 3'h0;
      cyc(80);
      fchk(6'h04);
      // ==========================================================
      // single pulsed input toggling banks A and B
      wr(ags_pkg::OFS_CTRL, 32'h00000412);
      wr(ags_pkg::OFS_QUAL, 32'h00000001);
      wr(ags_pkg::OFS_CMD, 32'h00000001);
      settle;
      fchk(6'h01);
      cyc(30);
      fx = n_frz;
      fire <= 1'b1;
      @(posedge mclk_i);
      fire <= 1'b0;
      settle;
      cyc(40);
      chk("one change per pulse", fx + 1, n_frz);
      rd("status", ags_pkg::OFS_STATUS, 32'h00000308);
      chk("nv fail", 32'h1, {31'h0, nv_fail});
      // thirteen bank changes in the whole run, past the endurance limit of three
      rd("store count", ags_pkg::OFS_NVCNT, 32'h0000000D);
      chk("store strobes", 32'h0000000D, n_wr);
      chk("freeze windows", 32'h0000000D, n_frz);
      chk("freeze length", FRZ, frz_len);
      chk("timers held in freeze", 0, bad_tr);
      chk("stored bank", 32'h4, {29'h0, last_nv});
      // power cycle brings back the stored bank
      resetn_i <= 1'b0;
      nv_restore <= last_nv;
      cyc(2);
      resetn_i <= 1'b1;
      cyc(3);
      fchk(6'h08);
      give_verdict;
   end
endmodule // active_group_selector_tb
`default_nettype wire
